// ---- common/sbc_mode_params.svh ----
// Purpose: Timing counts, field positions and codes for the mode controller
// Assumes: System clock of 125 MHz
// Notes:   Counts in ms are counted in ticks of the millisecond prescaler
`ifndef SBC_MODE_PARAMS_SVH
`define SBC_MODE_PARAMS_SVH

`define SYS_CLK_MHZ        125
`define TICK_MS            1
`define TICK_CYCLES        (`TICK_MS * 1000 * `SYS_CLK_MHZ)
`define WAKE_PHASE_NS      1000
`define WAKE_PHASE_CYCLES  ((`WAKE_PHASE_NS * `SYS_CLK_MHZ + 999) / 1000)
`define WAKE_TO_MS         2
`define SILENCE_TO_MS      1000
`define WD_PERIOD_MIN_MS   8
`define WD_PERIOD_MAX_MS   4000
`define WD_PERIOD1_MS      16
`define WD_PERIOD2_MS      32
`define WD_PERIOD3_MS      64
`define WD_PERIOD4_MS      128
`define WD_PERIOD5_MS      256
`define WD_PERIOD6_MS      1024
`define RST_LEN0_MS        1
`define RST_LEN1_MS        4
`define RST_LEN2_MS        10
`define RST_LEN3_MS        20
`define UV_THR0_PCT        60
`define UV_THR1_PCT        70
`define UV_THR2_PCT        80
`define UV_THR3_PCT        90
`define MODE_CTRL_ADDR     7'h01
`define MSEL_MSB           2
`define MSEL_LSB           0
`define MSEL_STANDBY       3'h4
`define MSEL_NORMAL        3'h7
`define FRAME_LEN16        6'h10
`define FRAME_LEN24        6'h18
`define FRAME_LEN32        6'h20
`define CANM_OFFLINE       2'h0
`define CANM_LISTEN        2'h3
`define WDM_OFF            2'h0
`define WDM_WINDOW         2'h1
`define WDM_TIMEOUT        2'h2
`define WDM_AUTO           2'h3

`endif

// ---- common/sbc_mode_pkg.sv ----
// Purpose: Types shared by the mode controller and its bench
// Assumes: Nothing
// Notes:   Codes of the enums run from 0 in declaration order
package sbc_mode_pkg;

   typedef enum logic [2:0] {
      MODE_OFF, MODE_RESET, MODE_STANDBY, MODE_NORMAL, MODE_FNORMAL, MODE_OVERTEMP
   } mode_t;

   typedef enum logic [1:0] {WK_IDLE, WK_DOM1, WK_REC} wake_phase_t;

   typedef struct packed {
      logic       busWakeEnable;
      logic [1:0] canModeSel;
      logic [1:0] wdModeSel;
      logic [2:0] wdPeriodSel;
      logic       cyclicWakeEn;
      logic [1:0] uvThrSel;
      logic [1:0] rstLenSel;
      logic       otWarnEnable;
      logic       forcedNormal;
   } cfg_t;

   typedef struct packed {
      logic txEn;
      logic rxEn;
      logic biasMid;
      logic biasEn;
   } can_ctl_t;

   typedef struct packed {
      mode_t       mode;
      logic [13:0] sync1;
      logic [13:0] sync2;
      logic        selPrev;
      logic        otwPrev;
      logic [16:0] tickCnt;
      logic        tick;
      logic [12:0] wdCnt;
      logic        wdArm;
      logic        wdActive;
      logic [4:0]  rstCnt;
      logic        rstDone;
      logic        resetOe_n;
      logic [9:0]  silCnt;
      wake_phase_t wkPhase;
      logic [7:0]  runCnt;
      logic        runLvl;
      logic [1:0]  wkToCnt;
      logic [2:0]  wakeSrc;
      logic [2:0]  readSel;
      can_ctl_t    can;
      logic        rxd;
      logic        supplyOn;
   } sys_state_t;

   typedef struct packed {
      logic [31:0] shift;
      logic [5:0]  bitCnt;
      logic        rdHit;
   } spi_state_t;

endpackage : sbc_mode_pkg

// ---- core/sbc_mode_controller.sv ----
// Purpose: Operating-mode controller with serial mode select and wake logic
// Assumes: Pins are asynchronous; cfg, wdTrigger and wakeClear are on clk_sys
// Notes:   Serial frame logic runs on serialClk; a frame restarts on its first bit
//
// Behaviour
// - Six modes: Normal, Standby, Reset, ForcedNormal, Overtemp, Off
// - Normal keeps supply on, all functions available
// - Normal allows active CAN, window/timeout watchdog
// - Standby to Normal on select value 111
// - Normal to Standby on select value 100
// - Standby neither transmits nor receives CAN
// - Standby keeps serial, supply; watchdog timeout only
// - Standby monitors bus wake when enabled
// - Bias ground after silence, mid while active
// - Receive output low on enabled wake event
// - Off to Reset to Standby on battery
// - Overtemp to Reset to Standby when cool
// - Watchdog period selectable 8 ms to 4 s
// - Window, timeout, autonomous; cyclic wake in Standby timeout
// - Wake capture re-enables the watchdog
// - Accept serial frames of 16, 24, 32 bits
// - Supply undervoltage reset at selectable threshold
// - Standard wake pattern, source recorded, disableable
// - Open-drain reset line, configurable pulse length
// - Reset holds line low, exits when high
// - Mode select in bits 2:0, address 01
`timescale 1ns/1ps
`default_nettype none
`include "sbc_mode_params.svh"

module sbc_mode_controller #(
   parameter int TICK_CYCLES = `TICK_CYCLES   // Cycles per millisecond tick
) (
   input  wire logic                clk_sys,          // System clock
   input  wire logic                reset_line_n,             // Async reset, active low
   input  wire logic                clkEn,            // Freezes system state when low
   input  wire logic                serialClk,        // Serial link clock
   input  wire logic                serialSelect_n,   // Serial frame select, active low
   input  wire logic                serialIn,         // Serial data in
   output var  logic                serialOut,        // Serial data out
   output var  logic                serialOutOe_n,    // Serial out enable, active low
   input  wire logic                batterySupplyOk,  // Battery above power-on level
   input  wire logic                tempShutdown,     // Chip above shutdown level
   input  wire logic                tempRelease,      // Chip below release level
   input  wire logic                tempWarning,      // Chip above warning level
   input  wire logic [6:0]          supplyPercent,    // Supply output in percent
   input  wire logic                resetLineIn_n,    // Reset line level
   output var  logic                resetLineOut_n,   // Reset line drive level
   output var  logic                resetLineOe_n,    // Reset line enable, active low
   input  wire logic                busDominant,      // Receiver sees dominant bus
   output var  logic                rxdOut,           // Receive data output
   output var  sbc_mode_pkg::can_ctl_t canCtl,        // Transceiver controls
   input  wire sbc_mode_pkg::cfg_t  cfg,              // Configuration bits
   input  wire logic                wdTrigger,        // Watchdog service pulse
   input  wire logic                wakeClear,        // Clears wake sources
   output var  sbc_mode_pkg::mode_t modeState,        // Active operating mode
   output var  logic                microSupplyRail,  // Supply regulator enable
   output var  logic                watchdogActive,   // Watchdog running
   output var  logic [2:0]          wakeSource        // Cyclic, warning, bus wake
);
   import sbc_mode_pkg::*;

   localparam int S_BAT  = 7;
   localparam int S_HOT  = 8;
   localparam int S_COOL = 9;
   localparam int S_WARN = 10;
   localparam int S_RST  = 11;
   localparam int S_DOM  = 12;
   localparam int S_SEL  = 13;

   sys_state_t  st_q;
   sys_state_t  st_d;
   spi_state_t  spi_q;
   spi_state_t  spi_d;
   logic        sdo_q;
   logic        sdoOe_n_q;
   logic        frameFresh_q;
   logic        frameRst_n;
   logic [13:0] pinVec;

   logic        batOk;
   logic        busDom;
   logic        underVolt;
   logic        selRise;
   logic        frameOk;
   logic [7:0]  byte0;
   logic [7:0]  byte1;
   logic        selWrite;
   logic [2:0]  selVal;
   logic [1:0]  wdEff;
   logic [12:0] wdPer;
   logic        wdRst;
   logic        extRst;
   logic        rstEvt;
   logic        qual;
   logic [2:0]  wakeEvt;
   logic        inUse;
   logic        bitStream;
   mode_t       modeNext;

   // =====================================================================
   // Lookup tables
   function automatic logic [12:0] wdPeriod(input logic [2:0] sel);
      unique case (sel)
         3'h0: wdPeriod = 13'(`WD_PERIOD_MIN_MS);
         3'h1: wdPeriod = 13'(`WD_PERIOD1_MS);
         3'h2: wdPeriod = 13'(`WD_PERIOD2_MS);
         3'h3: wdPeriod = 13'(`WD_PERIOD3_MS);
         3'h4: wdPeriod = 13'(`WD_PERIOD4_MS);
         3'h5: wdPeriod = 13'(`WD_PERIOD5_MS);
         3'h6: wdPeriod = 13'(`WD_PERIOD6_MS);
         3'h7: wdPeriod = 13'(`WD_PERIOD_MAX_MS);
      endcase
   endfunction : wdPeriod

   function automatic logic [4:0] rstLen(input logic [1:0] sel);
      unique case (sel)
         2'h0: rstLen = 5'(`RST_LEN0_MS);
         2'h1: rstLen = 5'(`RST_LEN1_MS);
         2'h2: rstLen = 5'(`RST_LEN2_MS);
         2'h3: rstLen = 5'(`RST_LEN3_MS);
      endcase
   endfunction : rstLen

   function automatic logic [6:0] uvThr(input logic [1:0] sel);
      unique case (sel)
         2'h0: uvThr = 7'(`UV_THR0_PCT);
         2'h1: uvThr = 7'(`UV_THR1_PCT);
         2'h2: uvThr = 7'(`UV_THR2_PCT);
         2'h3: uvThr = 7'(`UV_THR3_PCT);
      endcase
   endfunction : uvThr

   // =====================================================================
   // Serial link domain
   assign frameRst_n = reset_line_n & ~serialSelect_n;

   always_comb begin
      spi_d       = spi_q;
      spi_d.shift = {spi_q.shift[30:0], serialIn};
      if (spi_q.bitCnt != 6'h3F) begin
         spi_d.bitCnt = spi_q.bitCnt + 6'h01;
      end
      if (spi_q.bitCnt == 6'h07) begin
         spi_d.rdHit = (spi_d.shift[7:1] == `MODE_CTRL_ADDR) & spi_d.shift[0];
      end
      // Frame kept after select rises so the system side can decode it
      if (frameFresh_q) begin
         spi_d.shift  = {31'h00000000, serialIn};
         spi_d.bitCnt = 6'h01;
         spi_d.rdHit  = 1'b0;
      end
   end

   always_ff @(posedge serialClk or negedge reset_line_n) begin
      if (!reset_line_n) begin
         spi_q <= '0;
      end else begin
         spi_q <= spi_d;
      end
   end

   // Read data shifts out on the falling edge; readSel is frozen in a frame
   always_ff @(negedge serialClk or negedge frameRst_n) begin
      if (!frameRst_n) begin
         sdo_q     <= 1'b0;
         sdoOe_n_q    <= 1'b1;
         frameFresh_q <= 1'b1;
      end else begin
         sdoOe_n_q    <= 1'b0;
         frameFresh_q <= 1'b0;
         if (spi_q.rdHit && spi_q.bitCnt >= 6'h0D && spi_q.bitCnt <= 6'h0F) begin
            sdo_q <= st_q.readSel[2'(6'h0F - spi_q.bitCnt)];
         end else begin
            sdo_q <= 1'b0;
         end
      end
   end

   // =====================================================================
   // System domain
   assign pinVec = {serialSelect_n, busDominant, resetLineIn_n, tempWarning,
                    tempRelease, tempShutdown, batterySupplyOk, supplyPercent};

   always_comb begin
      st_d      = st_q;
      modeNext  = st_q.mode;
      batOk     = st_q.sync2[S_BAT];
      busDom    = st_q.sync2[S_DOM];
      underVolt = st_q.sync2[6:0] < uvThr(cfg.uvThrSel);
      inUse     = (st_q.mode == MODE_STANDBY) || (st_q.mode == MODE_NORMAL) ||
                  (st_q.mode == MODE_FNORMAL);
      wdEff     = `WDM_OFF;
      wdPer     = wdPeriod(cfg.wdPeriodSel);
      wdRst     = 1'b0;
      wakeEvt   = 3'h0;
      qual      = 1'b0;
      byte0     = 8'h00;
      byte1     = 8'h00;
      frameOk   = 1'b1;

      st_d.sync1   = pinVec;
      st_d.sync2   = st_q.sync1;
      st_d.selPrev = st_q.sync2[S_SEL];
      st_d.otwPrev = st_q.sync2[S_WARN];

      // Millisecond prescaler
      if (st_q.tickCnt == 17'(TICK_CYCLES - 1)) begin
         st_d.tickCnt = 17'h00000;
         st_d.tick    = 1'b1;
      end else begin
         st_d.tickCnt = st_q.tickCnt + 17'h00001;
         st_d.tick    = 1'b0;
      end

      // Frame decode once the select release has been synchronised
      selRise = st_q.sync2[S_SEL] & ~st_q.selPrev;
      unique case (spi_q.bitCnt)
         `FRAME_LEN16: begin
            byte0 = spi_q.shift[15:8];
            byte1 = spi_q.shift[7:0];
         end
         `FRAME_LEN24: begin
            byte0 = spi_q.shift[23:16];
            byte1 = spi_q.shift[15:8];
         end
         `FRAME_LEN32: begin
            byte0 = spi_q.shift[31:24];
            byte1 = spi_q.shift[23:16];
         end
         default: frameOk = 1'b0;
      endcase
      selWrite = selRise & frameOk & inUse & (st_q.mode != MODE_FNORMAL) &
                 (byte0[7:1] == `MODE_CTRL_ADDR) & ~byte0[0];
      selVal   = byte1[`MSEL_MSB:`MSEL_LSB];
      if (st_q.sync2[S_SEL]) begin
         st_d.readSel = (st_q.mode == MODE_STANDBY) ? `MSEL_STANDBY :
                        inUse ? `MSEL_NORMAL : 3'h0;
      end

      // Watchdog mode follows the operating mode
      if (st_q.mode == MODE_NORMAL && cfg.wdModeSel != `WDM_OFF) begin
         wdEff = (cfg.wdModeSel == `WDM_WINDOW) ? `WDM_WINDOW : `WDM_TIMEOUT;
      end else if (st_q.mode == MODE_STANDBY) begin
         if (cfg.wdModeSel == `WDM_WINDOW || cfg.wdModeSel == `WDM_TIMEOUT ||
             (cfg.wdModeSel == `WDM_AUTO && st_q.wdArm)) begin
            wdEff = `WDM_TIMEOUT;
         end
      end
      if (wdEff == `WDM_OFF) begin
         st_d.wdCnt = 13'h0000;
      end else if (wdTrigger) begin
         st_d.wdCnt = 13'h0000;
         wdRst      = (wdEff == `WDM_WINDOW) && (st_q.wdCnt < (wdPer >> 1));
      end else if (st_q.wdCnt >= wdPer) begin
         st_d.wdCnt = 13'h0000;
         if (cfg.cyclicWakeEn && st_q.mode == MODE_STANDBY) begin
            wakeEvt[2] = 1'b1;
         end else begin
            wdRst = 1'b1;
         end
      end else if (st_q.tick) begin
         st_d.wdCnt = st_q.wdCnt + 13'h0001;
      end
      st_d.wdActive = (wdEff != `WDM_OFF);

      // Bus silence and autonomous biasing
      if (busDom) begin
         st_d.silCnt = 10'h000;
      end else if (st_q.tick && st_q.silCnt < 10'(`SILENCE_TO_MS)) begin
         st_d.silCnt = st_q.silCnt + 10'h001;
      end

      // Wake pattern: dominant, recessive, dominant phases
      if (busDom != st_q.runLvl) begin
         st_d.runLvl = busDom;
         st_d.runCnt = 8'h00;
      end else if (st_q.runCnt != 8'hFF) begin
         st_d.runCnt = st_q.runCnt + 8'h01;
         qual        = (st_q.runCnt == 8'(`WAKE_PHASE_CYCLES - 1));
      end
      if (!cfg.busWakeEnable || !(st_q.mode == MODE_STANDBY || st_q.mode == MODE_RESET ||
          (st_q.mode == MODE_NORMAL && cfg.canModeSel == `CANM_OFFLINE))) begin
         st_d.wkPhase = WK_IDLE;
      end else begin
         unique case (st_q.wkPhase)
            WK_IDLE: begin
               st_d.wkToCnt = 2'h0;
               if (qual && busDom) begin
                  st_d.wkPhase = WK_DOM1;
               end
            end
            WK_DOM1: begin
               if (qual && !busDom) begin
                  st_d.wkPhase = WK_REC;
               end
            end
            WK_REC: begin
               if (qual && busDom) begin
                  wakeEvt[0]   = 1'b1;
                  st_d.wkPhase = WK_IDLE;
               end
            end
         endcase
         if (st_q.wkPhase != WK_IDLE && st_q.tick) begin
            st_d.wkToCnt = st_q.wkToCnt + 2'h1;
            if (st_q.wkToCnt >= 2'(`WAKE_TO_MS - 1)) begin
               st_d.wkPhase = WK_IDLE;
            end
         end
      end
      wakeEvt[1] = cfg.otWarnEnable & st_q.sync2[S_WARN] & ~st_q.otwPrev;

      // Wake capture: a new event wins over a clear in the same cycle
      if (st_q.mode == MODE_OFF || st_q.mode == MODE_OVERTEMP) begin
         wakeEvt = 3'h0;
      end
      st_d.wakeSrc = (wakeClear ? 3'h0 : st_q.wakeSrc) | wakeEvt;
      if (|wakeEvt) begin
         st_d.wdArm = 1'b1;
      end

      // Reset sources seen in the running modes
      extRst = st_q.resetOe_n & ~st_q.sync2[S_RST];
      rstEvt = inUse & (underVolt | wdRst | extRst);

      // Operating mode machine
      unique case (st_q.mode)
         MODE_OFF: begin
            if (batOk) begin
               modeNext = MODE_RESET;
            end
         end
         MODE_OVERTEMP: begin
            if (st_q.sync2[S_COOL]) begin
               modeNext = MODE_RESET;
            end
         end
         MODE_RESET: begin
            if (st_q.rstDone && st_q.resetOe_n && st_q.sync2[S_RST] && !underVolt) begin
               modeNext = cfg.forcedNormal ? MODE_FNORMAL : MODE_STANDBY;
            end
         end
         MODE_STANDBY: begin
            if (selWrite && selVal == `MSEL_NORMAL) begin
               modeNext = MODE_NORMAL;
            end
         end
         MODE_NORMAL: begin
            if (selWrite && selVal == `MSEL_STANDBY) begin
               modeNext = MODE_STANDBY;
            end
         end
         MODE_FNORMAL: begin
            modeNext = MODE_FNORMAL;
         end
      endcase
      if (rstEvt) begin
         modeNext = MODE_RESET;
      end
      if (st_q.sync2[S_HOT] && st_q.mode != MODE_OFF) begin
         modeNext = MODE_OVERTEMP;
      end
      if (!batOk) begin
         modeNext = MODE_OFF;
      end
      st_d.mode = modeNext;
      if (modeNext != st_q.mode) begin
         st_d.wdCnt = 13'h0000;
      end
      if (modeNext == MODE_NORMAL) begin
         st_d.wdArm = 1'b0;
      end

      // Reset pulse timing
      if (modeNext == MODE_RESET && st_q.mode != MODE_RESET) begin
         st_d.rstCnt  = 5'h00;
         st_d.rstDone = 1'b0;
      end else if (st_q.mode == MODE_RESET && st_q.tick && !st_q.rstDone) begin
         if (st_q.rstCnt == rstLen(cfg.rstLenSel) - 5'h01) begin
            st_d.rstDone = 1'b1;
         end else begin
            st_d.rstCnt = st_q.rstCnt + 5'h01;
         end
      end
      st_d.resetOe_n = !(modeNext == MODE_OFF || modeNext == MODE_OVERTEMP ||
                         (modeNext == MODE_RESET && !st_d.rstDone));

      // Pin controls from the next mode
      st_d.supplyOn = (modeNext == MODE_NORMAL) || (modeNext == MODE_STANDBY) ||
                      (modeNext == MODE_RESET) || (modeNext == MODE_FNORMAL);
      st_d.can.txEn = (modeNext == MODE_FNORMAL) || (modeNext == MODE_NORMAL &&
                      cfg.canModeSel != `CANM_OFFLINE && cfg.canModeSel != `CANM_LISTEN);
      bitStream     = (modeNext == MODE_FNORMAL) ||
                      (modeNext == MODE_NORMAL && cfg.canModeSel != `CANM_OFFLINE);
      st_d.can.rxEn = bitStream;
      st_d.can.biasEn  = (modeNext != MODE_OFF) && (modeNext != MODE_OVERTEMP);
      st_d.can.biasMid = bitStream || (st_d.silCnt < 10'(`SILENCE_TO_MS));
      if (bitStream) begin
         st_d.rxd = ~busDom;
      end else begin
         st_d.rxd = ~(|st_d.wakeSrc) || (modeNext == MODE_OFF);
      end

      if (!clkEn) begin
         st_d = st_q;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_line_n) begin
      if (!reset_line_n) begin
         st_q      <= '0;
         st_q.mode <= MODE_OFF;
         st_q.rxd  <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // =====================================================================
   // Outputs
   assign serialOut       = sdo_q;
   assign serialOutOe_n   = sdoOe_n_q;
   assign resetLineOut_n  = 1'b0;
   assign resetLineOe_n   = st_q.resetOe_n;
   assign rxdOut          = st_q.rxd;
   assign canCtl          = st_q.can;
   assign modeState       = st_q.mode;
   assign microSupplyRail = st_q.supplyOn;
   assign watchdogActive  = st_q.wdActive;
   assign wakeSource      = st_q.wakeSrc;

endmodule : sbc_mode_controller
`default_nettype wire

// ---- dv/sbc_mode_monitor.sv ----
// Purpose: Checker for the mode controller ports
// Assumes: clkEn held high by the bench
// Notes:   Attached to every controller instance by bind
`timescale 1ns/1ps
`default_nettype none
module sbc_mode_monitor (
   input wire logic                 clk_sys,         // System clock
   input wire logic                 reset_line_n,            // Async reset, active low
   input wire logic                 batterySupplyOk, // Battery pin
   input wire logic                 tempShutdown,    // Hot pin
   input wire logic                 resetLineIn_n,   // Reset line level
   input wire logic                 resetLineOe_n,   // Reset line enable
   input wire logic                 rxdOut,          // Receive output
   input wire sbc_mode_pkg::can_ctl_t canCtl,        // Transceiver controls
   input wire sbc_mode_pkg::mode_t  modeState,       // Active mode
   input wire logic                 microSupplyRail, // Regulator enable
   input wire logic [2:0]           wakeSource       // Wake sources
);
   import sbc_mode_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_line_n);
   // ======
   // Mode checks
   a_off_nobat: assert property (!batterySupplyOk [*5] |-> modeState == MODE_OFF)
      else $error("mode not off without battery");
   a_hot_overtemp: assert property ((tempShutdown && batterySupplyOk) [*6]
      |-> modeState == MODE_OVERTEMP) else $error("hot chip not in overtemp");
   a_normal_entry: assert property ($changed(modeState) && modeState == MODE_NORMAL
      |-> $past(modeState) == MODE_STANDBY) else $error("normal entered wrongly");
   a_standby_entry: assert property ($changed(modeState) && modeState == MODE_STANDBY
      |-> $past(modeState) inside {MODE_NORMAL, MODE_RESET})
      else $error("standby entered wrongly");
   a_reset_pull: assert property ($rose(modeState == MODE_RESET) |-> !resetLineOe_n)
      else $error("reset line not pulled");
   a_reset_exit: assert property ($past(modeState) == MODE_RESET
      && modeState == MODE_STANDBY |-> resetLineOe_n && $past(resetLineIn_n, 2))
      else $error("reset left with line low");
   a_standby_quiet: assert property (modeState == MODE_STANDBY
      && $past(modeState) == MODE_STANDBY |-> !canCtl.txEn && !canCtl.rxEn)
      else $error("transceiver active in standby");
   a_supply_kept: assert property ((modeState inside {MODE_NORMAL, MODE_STANDBY}) [*2]
      |-> microSupplyRail) else $error("supply off in standby or normal");
   a_wake_rxd: assert property ((modeState == MODE_STANDBY && wakeSource != 3'h0) [*2]
      |-> !rxdOut) else $error("receive output high with wake");
endmodule : sbc_mode_monitor
bind sbc_mode_controller sbc_mode_monitor i_mon (.clk_sys(clk_sys), .reset_line_n(reset_line_n),
   .batterySupplyOk(batterySupplyOk), .tempShutdown(tempShutdown),
   .resetLineIn_n(resetLineIn_n), .resetLineOe_n(resetLineOe_n), .rxdOut(rxdOut),
   .canCtl(canCtl), .modeState(modeState), .microSupplyRail(microSupplyRail),
   .wakeSource(wakeSource));
`default_nettype wire

// ---- dv/sbc_host_model.sv ----
// Purpose: Host side of the serial link and reset line
// Assumes: Link clock of 15 ns, idle low outside frames
// Notes:   Reset line has a pull-up
`timescale 1ns/1ps
`default_nettype none
module sbc_host_model (
   output var logic  serialClk,      // Link clock
   output var logic  serialSelect_n, // Frame select, active low
   output var logic  serialIn,       // Data to device
   input wire logic  serialOut,      // Data from device
   input wire logic  resetLineOut_n, // Device drive level
   input wire logic  resetLineOe_n,  // Device drive enable
   output var logic  resetLineIn_n   // Resolved line level
);
   assign resetLineIn_n = resetLineOe_n ? 1'b1 : resetLineOut_n;
   initial begin
      serialClk = 1'b0;
      serialSelect_n = 1'b1;
      serialIn = 1'b0;
   end
   // Frame of nBits, MSB first; write data in bits 2:0 of byte 1
   task automatic xfer(input logic [31:0] tx, input int nBits, output logic [31:0] rx);
      rx = '0;
      serialSelect_n = 1'b0;
      #20;
      for (int i = 0; i < nBits; i++) begin
         serialIn = tx[31-i];
         #7.5 serialClk = 1'b1;
         rx = {rx[30:0], serialOut};
         #7.5 serialClk = 1'b0;
      end
      #20 serialSelect_n = 1'b1;
      serialIn = ~serialIn;
      #60;
   endtask : xfer
endmodule : sbc_host_model
`default_nettype wire

// ---- dv/sbc_mode_controller_tb.sv ----
// Purpose: Self-checking bench of the mode controller
// Assumes: Short millisecond tick for speed
// Notes:   Mode changes are checked against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module sbc_mode_controller_tb;
   import sbc_mode_pkg::*;
   logic        clk_sys, reset_line_n, batterySupplyOk, tempShutdown, tempRelease, busDominant;
   logic        wakeClear, serialClk, serialSelect_n, serialIn, serialOut, rxdOut;
   logic        resetLineOut_n, resetLineOe_n, resetLineIn_n, microSupplyRail;
   logic [2:0]  wakeSource, lastMode, e, v;
   logic [2:0]  expQ[$];
   logic [31:0] rx;
   can_ctl_t    canCtl;
   cfg_t        cfg;
   mode_t       modeState;
   int          n_fail, compares, seed, k;
   always #4 clk_sys = ~clk_sys;
   sbc_mode_controller #(.TICK_CYCLES(1000)) i_dut (.clk_sys(clk_sys), .reset_line_n(reset_line_n),
      .clkEn(1'b1), .serialClk(serialClk), .serialSelect_n(serialSelect_n),
      .serialIn(serialIn), .serialOut(serialOut), .serialOutOe_n(),
      .batterySupplyOk(batterySupplyOk), .tempShutdown(tempShutdown),
      .tempRelease(tempRelease), .tempWarning(1'b0), .supplyPercent(7'h64),
      .resetLineIn_n(resetLineIn_n), .resetLineOut_n(resetLineOut_n),
      .resetLineOe_n(resetLineOe_n), .busDominant(busDominant), .rxdOut(rxdOut),
      .canCtl(canCtl), .cfg(cfg), .wdTrigger(1'b0), .wakeClear(wakeClear),
      .modeState(modeState), .microSupplyRail(microSupplyRail), .watchdogActive(),
      .wakeSource(wakeSource));
   sbc_host_model i_host (.serialClk(serialClk), .serialSelect_n(serialSelect_n),
      .serialIn(serialIn), .serialOut(serialOut), .resetLineOut_n(resetLineOut_n),
      .resetLineOe_n(resetLineOe_n), .resetLineIn_n(resetLineIn_n));
   // ======
   // Checking
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic finish_test;
      $display("fails %0d compares %0d", n_fail, compares);
      if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   always @(negedge clk_sys) begin
      if (reset_line_n && modeState !== lastMode) begin
         e = expQ.size() > 0 ? expQ.pop_front() : ~modeState;
         chk({29'h0, modeState}, {29'h0, e}, "modeState");
      end
      lastMode = modeState;
   end
   // ======
   // Stimulus
   task automatic wt(input mode_t m);
      for (int i = 0; i < 2000 && modeState !== m; i++) @(negedge clk_sys);
      if (modeState !== m) begin
         n_fail++;
         finish_test();
      end
   endtask : wt
   task automatic go(input mode_t m);
      expQ.push_back(m);
      wt(m);
   endtask : go
   task automatic mv(input logic [2:0] val, input int len, input mode_t m);
      if (m !== modeState) expQ.push_back(m);
      i_host.xfer({8'h02, 5'h00, val, 16'h0000}, len, rx);
      wt(m);
      repeat (10) @(negedge clk_sys);
   endtask : mv
   task automatic rd(input logic [2:0] m);
      i_host.xfer(32'h0300_0000, 16, rx);
      chk(rx[7:0], {5'h00, m}, "readMode");
   endtask : rd
   task automatic wake(input logic en);
      cfg.busWakeEnable = en;
      for (k = 0; k < 4; k++) begin
         busDominant = !k[0];
         repeat (130) @(negedge clk_sys);
      end
      chk(wakeSource[0], en, "busWake");
   endtask : wake
   initial begin
      {clk_sys, reset_line_n, batterySupplyOk, tempShutdown, busDominant, wakeClear} = '0;
      tempRelease = 1'b1;
      seed = 60749;
      n_fail = 0;
      compares = 0;
      lastMode = MODE_OFF;
      cfg = '0;
      cfg.canModeSel = 2'h1;
      repeat (6) @(negedge clk_sys);
      reset_line_n = 1'b1;
      @(negedge clk_sys);
      batterySupplyOk = 1'b1;
      expQ.push_back(MODE_RESET);
      go(MODE_STANDBY);
      mv(3'h7, 16, MODE_NORMAL);
      chk(canCtl.txEn, 1'b1, "txEn");
      rd(3'h7);
      for (int n = 16; n <= 32; n += 8) begin
         mv(3'h4, n, MODE_STANDBY);
         mv(3'h7, n, MODE_NORMAL);
      end
      mv(3'h4, 16, MODE_STANDBY);
      chk(canCtl.txEn, 1'b0, "txEn");
      rd(3'h4);
      mv(3'h4, 16, MODE_STANDBY);
      mv(3'h7, 20, MODE_STANDBY);
      v = 3'($random(seed));
      if (v == 3'h7) v = 3'h5;
      mv(v, 16, MODE_STANDBY);
      wake(1'b0);
      wake(1'b1);
      chk(rxdOut, 1'b0, "rxdOut");
      chk(canCtl.biasMid, 1'b1, "biasMid");
      wakeClear = 1'b1;
      @(negedge clk_sys);
      wakeClear = 1'b0;
      repeat (6) @(negedge clk_sys);
      chk(rxdOut, 1'b1, "rxdOut");
      tempShutdown = 1'b1;
      tempRelease = 1'b0;
      go(MODE_OVERTEMP);
      tempShutdown = 1'b0;
      tempRelease = 1'b1;
      expQ.push_back(MODE_RESET);
      go(MODE_STANDBY);
      batterySupplyOk = 1'b0;
      go(MODE_OFF);
      repeat (5) @(negedge clk_sys);
      chk(expQ.size(), 0, "pendingModes");
      finish_test();
   end
endmodule : sbc_mode_controller_tb
`default_nettype wire
